// ===== include/touch_pkg.sv
package touch_pkg;

  function automatic int unsigned ns_to_cyc(input int unsigned ns, input int unsigned per);
    ns_to_cyc = (ns + per - 1) / per;
  endfunction

  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned FAST_GAP_NS     = 1000000;
  localparam int unsigned LP_SLEEP_NS     = 80000000;
  localparam int unsigned HEALTH_NS       = 15000;
  localparam int unsigned MIN_PULSE_NS    = 10000;
  localparam int unsigned SHORT_PULSE_NS  = 2450000;
  localparam int unsigned FAST_GAP_CYC    = ns_to_cyc(FAST_GAP_NS, CLK_PERIOD_NS);
  localparam int unsigned LP_SLEEP_CYC    = ns_to_cyc(LP_SLEEP_NS, CLK_PERIOD_NS);
  localparam int unsigned HEALTH_CYC      = ns_to_cyc(HEALTH_NS, CLK_PERIOD_NS);
  localparam int unsigned MIN_PULSE_CYC   = ns_to_cyc(MIN_PULSE_NS, CLK_PERIOD_NS);
  localparam int unsigned SHORT_PULSE_CYC = ns_to_cyc(SHORT_PULSE_NS, CLK_PERIOD_NS);

  localparam int unsigned SIG_W           = 12;
  localparam int          THRESHOLD       = 10;
  localparam int          HYSTERESIS      = 2;
  localparam int unsigned CONFIRM_COUNT   = 4;
  localparam int unsigned RECAL_BURSTS    = 64;
  localparam int unsigned DRIFT_UP_DIV    = 16;
  localparam int unsigned DRIFT_DN_DIV    = 2;
  localparam int          SPREAD_PERMILLE = 75;

  typedef enum logic [5:0] {
    ST_HEALTH    = 6'h01,
    ST_BURST     = 6'h02,
    ST_DECIDE    = 6'h04,
    ST_FAST      = 6'h08,
    ST_SLEEP     = 6'h10,
    ST_SYNC_WAIT = 6'h20
  } ctl_state_t;

  typedef enum logic [2:0] {
    MODE_FAST      = 3'h1,
    MODE_LOW_POWER = 3'h2,
    MODE_SYNC      = 3'h4
  } run_mode_t;

endpackage

// ===== include/filt_if.sv
`timescale 1ns/1ps
interface filt_if #(parameter int unsigned W = 12);
  logic         sample_valid;
  logic [W-1:0] sample;
  logic         sync_mode;
  logic         touch;
  logic         resolving;

  modport ctl  (output sample_valid, output sample, output sync_mode, input touch, input resolving);
  modport proc (input sample_valid, input sample, input sync_mode, output touch, output resolving);
endinterface

// ===== hdl/touch_filter.sv
`timescale 1ns/1ps
module touch_filter #(
  parameter int unsigned RECAL_N = touch_pkg::RECAL_BURSTS,
  parameter int unsigned UP_DIV  = touch_pkg::DRIFT_UP_DIV,
  parameter int unsigned DN_DIV  = touch_pkg::DRIFT_DN_DIV
) (
  input wire logic clk,
  input wire logic rst_sync_n,
  filt_if.proc     f
);
  import touch_pkg::*;

  logic [SIG_W-1:0]      ref_lvl;
  logic signed [SIG_W:0] delta;
  logic                  det_raw;
  logic                  need_cal;
  logic [2:0]            confirm_cnt;
  logic [15:0]           recal_cnt;
  logic [15:0]           up_acc;
  logic [15:0]           dn_acc;

  assign delta   = $signed({1'b0, f.sample}) - $signed({1'b0, ref_lvl});
  assign det_raw = f.touch ? (delta >= THRESHOLD - HYSTERESIS) : (delta >= THRESHOLD);

  // ----------------------------------------------------------------
  // calibration and recalibration timeout
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      need_cal  <= 1'b1;
      recal_cnt <= 16'h0;
    end else if (f.sample_valid) begin
      if (need_cal) begin
        need_cal  <= 1'b0;
        recal_cnt <= 16'h0;
      end else if (delta <= -THRESHOLD) begin
        // only a signal stuck far below the reference counts, never a touch
        if (32'(recal_cnt) >= RECAL_N - 1) begin
          need_cal <= 1'b1;
          recal_cnt <= 16'h0;
        end else begin
          recal_cnt <= recal_cnt + 16'h1;
        end
      end else begin
        recal_cnt <= 16'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // reference tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ref_lvl <= '0;
      up_acc  <= 16'h0;
      dn_acc  <= 16'h0;
    end else if (f.sample_valid) begin
      if (need_cal) begin
        ref_lvl <= f.sample;
        up_acc  <= 16'h0;
        dn_acc  <= 16'h0;
      end else if (!det_raw && !f.touch) begin
        if (f.sample > ref_lvl) begin
          dn_acc <= 16'h0;
          if (32'(up_acc) >= UP_DIV - 1) begin
            up_acc  <= 16'h0;
            ref_lvl <= ref_lvl + 1'b1;
          end else begin
            up_acc <= up_acc + 16'h1;
          end
        end else if (f.sample < ref_lvl) begin
          up_acc <= 16'h0;
          if (32'(dn_acc) >= DN_DIV - 1) begin
            dn_acc  <= 16'h0;
            ref_lvl <= ref_lvl - 1'b1;
          end else begin
            dn_acc <= dn_acc + 16'h1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // confirmation counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      confirm_cnt <= 3'h0;
      f.touch     <= 1'b0;
      f.resolving <= 1'b0;
    end else if (f.sample_valid) begin
      if (need_cal || !det_raw) begin
        confirm_cnt <= 3'h0;
        f.touch     <= 1'b0;
        f.resolving <= 1'b0;
      end else if (f.sync_mode) begin
        f.touch     <= 1'b1;
        f.resolving <= 1'b0;
      end else if (32'(confirm_cnt) >= CONFIRM_COUNT - 1) begin
        confirm_cnt <= 3'(CONFIRM_COUNT);
        f.touch     <= 1'b1;
        f.resolving <= 1'b0;
      end else begin
        confirm_cnt <= confirm_cnt + 3'h1;
        f.resolving <= 1'b1;
      end
    end
  end
endmodule

// ===== hdl/touch_key_burst_controller.sv
`timescale 1ns/1ps
module touch_key_burst_controller #(
  parameter int unsigned FAST_GAP_CYC_P    = touch_pkg::FAST_GAP_CYC,
  parameter int unsigned LP_SLEEP_CYC_P    = touch_pkg::LP_SLEEP_CYC,
  parameter int unsigned SHORT_PULSE_CYC_P = touch_pkg::SHORT_PULSE_CYC,
  parameter int unsigned RECAL_N           = touch_pkg::RECAL_BURSTS
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       sync_in,
  input  wire logic                       burst_done,
  input  wire logic [touch_pkg::SIG_W-1:0] burst_value,
  output logic                            burst_start,
  output logic signed [7:0]               osc_trim,
  output logic                            detect_out,
  output logic                            detect_oe,
  output touch_pkg::run_mode_t            run_mode
);
  import touch_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0]  rst_pipe;
  logic        rst_sync_n;
  ctl_state_t  state;
  ctl_state_t  next_state;
  logic [31:0] timer;
  logic        sync_d;
  logic        sync_rise;
  logic        sync_fall;
  logic        sync_at_end;
  logic [31:0] idle_cnt;
  logic        sync_timeout;
  logic [31:0] high_cnt;
  logic        short_mode;
  logic        wake_edge;
  logic        trim_up;

  filt_if #(.W(SIG_W)) f ();

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe[1];

  // ----------------------------------------------------------------
  // signal processing
  // ----------------------------------------------------------------
  assign f.sample_valid = burst_done && (state == ST_BURST);
  assign f.sample       = burst_value;
  assign f.sync_mode    = (run_mode == MODE_SYNC);

  touch_filter #(
    .RECAL_N (RECAL_N)
  ) u_filter (
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .f          (f)
  );

  // ----------------------------------------------------------------
  // sync pin history
  // ----------------------------------------------------------------
  assign sync_rise = sync_in && !sync_d;
  assign sync_fall = !sync_in && sync_d;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sync_d <= 1'b0;
    end else begin
      sync_d <= sync_in;
    end
  end

  // level taken at the end of each burst
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sync_at_end <= 1'b0;
    end else if (state == ST_BURST && burst_done) begin
      sync_at_end <= sync_in;
    end
  end

  // time since the last sync change, saturating just past the sleep period
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      idle_cnt <= 32'h0;
    end else if (sync_rise || sync_fall) begin
      idle_cnt <= 32'h0;
    end else if (idle_cnt <= LP_SLEEP_CYC_P) begin
      idle_cnt <= idle_cnt + 32'h1;
    end
  end

  assign sync_timeout = (idle_cnt > LP_SLEEP_CYC_P);

  // ----------------------------------------------------------------
  // short pulse detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      high_cnt <= 32'h0;
    end else if (!sync_in) begin
      high_cnt <= 32'h0;
    end else if (high_cnt < SHORT_PULSE_CYC_P) begin
      high_cnt <= high_cnt + 32'h1;
    end
  end

  // a high phase of pulse length switches wake-up to falling edges only
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      short_mode <= 1'b0;
    end else if (run_mode != MODE_SYNC) begin
      short_mode <= 1'b0;
    end else if (sync_fall) begin
      if (high_cnt >= MIN_PULSE_CYC && high_cnt < SHORT_PULSE_CYC_P) begin
        short_mode <= 1'b1;
      end else if (high_cnt >= SHORT_PULSE_CYC_P) begin
        short_mode <= 1'b0;
      end
    end
  end

  assign wake_edge = sync_fall || (sync_rise && !short_mode);

  // ----------------------------------------------------------------
  // run mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      run_mode <= MODE_FAST;
    end else if (state == ST_DECIDE) begin
      unique case (run_mode)
        MODE_FAST: begin
          if (!sync_at_end) begin
            run_mode <= MODE_SYNC;
          end
        end
        MODE_LOW_POWER: begin
          if (!f.resolving && sync_at_end) begin
            run_mode <= MODE_FAST;
          end
        end
        MODE_SYNC: begin
          run_mode <= MODE_SYNC;
        end
        default: begin
          run_mode <= MODE_FAST;
        end
      endcase
    end else if (state == ST_SYNC_WAIT && !wake_edge && sync_timeout) begin
      run_mode <= sync_d ? MODE_FAST : MODE_LOW_POWER;
    end
  end

  // ----------------------------------------------------------------
  // burst scheduler
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_HEALTH: begin
        if (timer >= HEALTH_CYC - 1) begin
          next_state = ST_BURST;
        end
      end
      ST_BURST: begin
        if (burst_done) begin
          next_state = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        unique case (run_mode)
          MODE_FAST: begin
            next_state = sync_at_end ? ST_FAST : ST_SYNC_WAIT;
          end
          MODE_LOW_POWER: begin
            if (f.resolving || sync_at_end) begin
              next_state = ST_FAST;
            end else begin
              next_state = ST_SLEEP;
            end
          end
          MODE_SYNC: begin
            next_state = ST_SYNC_WAIT;
          end
          default: begin
            next_state = ST_FAST;
          end
        endcase
      end
      ST_FAST: begin
        if (timer >= FAST_GAP_CYC_P - 1) begin
          next_state = ST_HEALTH;
        end
      end
      ST_SLEEP: begin
        if (timer >= LP_SLEEP_CYC_P - 1) begin
          next_state = ST_HEALTH;
        end
      end
      ST_SYNC_WAIT: begin
        if (wake_edge || sync_timeout) begin
          next_state = ST_HEALTH;
        end
      end
      default: begin
        next_state = ST_HEALTH;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ST_HEALTH;
    end else begin
      state <= next_state;
    end
  end

  // time spent in the current state
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      timer <= 32'h0;
    end else if (next_state != state) begin
      timer <= 32'h0;
    end else begin
      timer <= timer + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // front end strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      burst_start <= 1'b0;
    end else begin
      burst_start <= (state == ST_HEALTH) && (next_state == ST_BURST);
    end
  end

  // ----------------------------------------------------------------
  // spread spectrum trim
  // ----------------------------------------------------------------
  // triangle sweep across the band, centred outside bursts
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      osc_trim <= 8'sh0;
      trim_up  <= 1'b1;
    end else if (state != ST_BURST) begin
      osc_trim <= 8'sh0;
      trim_up  <= 1'b1;
    end else if (trim_up) begin
      if (osc_trim >= $signed(8'(SPREAD_PERMILLE)) - 8'sh1) begin
        trim_up <= 1'b0;
      end
      osc_trim <= osc_trim + 8'sh1;
    end else begin
      if (osc_trim <= 8'sh1 - $signed(8'(SPREAD_PERMILLE))) begin
        trim_up <= 1'b1;
      end
      osc_trim <= osc_trim - 8'sh1;
    end
  end

  // ----------------------------------------------------------------
  // detect pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      detect_out <= 1'b0;
    end else begin
      detect_out <= f.touch;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      detect_oe <= 1'b0;
    end else begin
      detect_oe <= (next_state != ST_HEALTH);
    end
  end
endmodule

// ===== tb/touch_key_burst_controller_assertions.sv
`timescale 1ns/1ps
module touch_key_burst_controller_checker #(
  parameter int unsigned FAST_GAP_CYC_P    = touch_pkg::FAST_GAP_CYC,
  parameter int unsigned LP_SLEEP_CYC_P    = touch_pkg::LP_SLEEP_CYC,
  parameter int unsigned SHORT_PULSE_CYC_P = touch_pkg::SHORT_PULSE_CYC,
  parameter int unsigned RECAL_N           = touch_pkg::RECAL_BURSTS
) (
  input wire logic                         clk,
  input wire logic                         rst_n,
  input wire logic                         sync_in,
  input wire logic                         burst_done,
  input wire logic [touch_pkg::SIG_W-1:0]  burst_value,
  input wire logic                         burst_start,
  input wire logic signed [7:0]            osc_trim,
  input wire logic                         detect_out,
  input wire logic                         detect_oe,
  input touch_pkg::run_mode_t              run_mode
);
  import touch_pkg::*;
  logic        in_burst;
  int unsigned oe_low;
  int unsigned age;
  logic        sync_q;
  int unsigned still;
  // ----
  // helper counters
  // ----
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) in_burst <= 1'b0;
    else if (burst_start) in_burst <= 1'b1;
    else if (burst_done) in_burst <= 1'b0;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) oe_low <= 0;
    else oe_low <= detect_oe ? 0 : oe_low + 1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) age <= 0;
    else age <= (burst_done && in_burst) ? 0 : age + 1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 1'b1;
      still  <= 0;
    end else begin
      sync_q <= sync_in;
      still  <= (sync_in != sync_q) ? 0 : still + 1;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_sweep;
    ##75 (osc_trim == 75) ##150 (osc_trim == -75);
  endsequence
  sequence s_health;
    (oe_low >= HEALTH_CYC) && (oe_low <= HEALTH_CYC + 3);
  endsequence
  AST_START_PULSE: assert property (burst_start |=> !burst_start && in_burst)
    else $error("burst start is not a single pulse");
  AST_HEALTH_LEN: assert property (burst_start |-> s_health)
    else $error("health release length wrong");
  AST_OE_RISE: assert property ($rose(detect_oe) |-> burst_start)
    else $error("output driven again without a burst");
  AST_TRIM_SWEEP: assert property (burst_start |-> s_sweep)
    else $error("trim sweep does not reach its limits");
  AST_TRIM_IDLE: assert property (!in_burst && !$past(in_burst) |-> osc_trim == 0)
    else $error("trim nonzero outside a burst");
  AST_DETECT_AFTER_BURST: assert property (!$stable(detect_out) |-> $past(burst_done, 2))
    else $error("detect changed without a burst result");
  AST_FAST_GAP: assert property ($fell(detect_oe) && run_mode == MODE_FAST &&
    $past(run_mode, 8) == MODE_FAST |-> age >= FAST_GAP_CYC_P && age <= FAST_GAP_CYC_P + 4)
    else $error("fast gap length wrong");
  AST_LP_GAP: assert property ($fell(detect_oe) && run_mode == MODE_LOW_POWER &&
    $past(run_mode, 8) == MODE_LOW_POWER |-> (age >= FAST_GAP_CYC_P && age <= FAST_GAP_CYC_P + 4) ||
    (age >= LP_SLEEP_CYC_P && age <= LP_SLEEP_CYC_P + 4))
    else $error("low power gap length wrong");
  AST_ENTER_SYNC: assert property (burst_done && in_burst && run_mode == MODE_FAST && !sync_in
    |-> ##[1:4] run_mode == MODE_SYNC)
    else $error("sync mode not entered");
  AST_SYNC_WAKE: assert property ($fell(sync_in) && run_mode == MODE_SYNC && !in_burst &&
    detect_oe && age > 2 && age < LP_SLEEP_CYC_P |=> !detect_oe)
    else $error("falling sync edge did not wake");
  AST_MODE_STEADY: assert property (!$stable(run_mode) |-> age <= 3 || still >= LP_SLEEP_CYC_P)
    else $error("mode changed outside a decision");
endmodule
bind touch_key_burst_controller touch_key_burst_controller_checker #(
  .FAST_GAP_CYC_P(FAST_GAP_CYC_P), .LP_SLEEP_CYC_P(LP_SLEEP_CYC_P),
  .SHORT_PULSE_CYC_P(SHORT_PULSE_CYC_P), .RECAL_N(RECAL_N)
) chk_inst (.clk(clk), .rst_n(rst_n), .sync_in(sync_in), .burst_done(burst_done),
  .burst_value(burst_value), .burst_start(burst_start), .osc_trim(osc_trim),
  .detect_out(detect_out), .detect_oe(detect_oe), .run_mode(run_mode));

// ===== tb/touch_front_end_model.sv
`timescale 1ns/1ps
module touch_front_end_model #(
  parameter int unsigned BURST_CYC = 240
) (
  input  wire logic                        clk,
  input  wire logic                        burst_start,
  input  wire logic [touch_pkg::SIG_W-1:0] value,
  output logic                             burst_done,
  output logic [touch_pkg::SIG_W-1:0]      burst_value
);
  import touch_pkg::*;
  int unsigned      cnt = 0;
  logic             done_q = 1'b0;
  logic [SIG_W-1:0] val_q = '0;
  // ----
  // burst timing
  // ----
  always @(posedge clk) begin
    done_q <= 1'b0;
    val_q <= ~val_q;
    if (burst_start) cnt <= BURST_CYC;
    else if (cnt == 1) begin
      cnt <= 0;
      done_q <= 1'b1;
      val_q <= value;
    end
    else if (cnt != 0) cnt <= cnt - 1;
  end
  // value toggles outside the done cycle
  assign burst_done = done_q;
  assign burst_value = val_q;
endmodule

// ===== tb/touch_key_burst_controller_test.sv
`timescale 1ns/1ps
module touch_key_burst_controller_test;
  import touch_pkg::*;
  localparam int unsigned FG  = 50;
  localparam int unsigned LPS = 4500;
  typedef struct {logic s; logic [SIG_W-1:0] v; logic d; run_mode_t m;} row_t;
  logic              clk;
  logic              rst_n;
  logic              sync_in;
  logic              burst_done;
  logic              burst_start;
  logic              detect_out;
  logic              detect_oe;
  logic [SIG_W-1:0]  burst_value;
  logic [SIG_W-1:0]  fe_value;
  logic signed [7:0] osc_trim;
  run_mode_t         run_mode;
  row_t              rows [14];
  int                bad_count = 0;
  int                compares = 0;
  int                cycles = 0;
  int                gap;
  touch_key_burst_controller #(.FAST_GAP_CYC_P(FG), .LP_SLEEP_CYC_P(LPS), .SHORT_PULSE_CYC_P(3000),
    .RECAL_N(8)) touch_key_burst_controller_inst (.clk(clk), .rst_n(rst_n), .sync_in(sync_in),
    .burst_done(burst_done), .burst_value(burst_value), .burst_start(burst_start),
    .osc_trim(osc_trim), .detect_out(detect_out), .detect_oe(detect_oe), .run_mode(run_mode));
  touch_front_end_model #(.BURST_CYC(240)) touch_front_end_model_inst (.clk(clk),
    .burst_start(burst_start), .value(fe_value), .burst_done(burst_done), .burst_value(burst_value));
  // ----
  // tasks
  // ----
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic do_burst(input logic [SIG_W-1:0] v);
    int n;
    n = 0;
    fe_value = v;
    while (burst_done !== 1'b1 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 8000) bad_count++;
    repeat (4) @(negedge clk);
  endtask
  task automatic gap_meas();
    gap = 0;
    while (detect_oe === 1'b1 && gap < 6000) begin
      @(negedge clk);
      gap++;
    end
  endtask
  // ----
  // clock and timeout
  // ----
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      bad_count++;
      final_report();
    end
  end
  // ----
  // sequence
  // ----
  initial begin
    rows = '{'{1, 12'h064, 0, MODE_FAST}, '{1, 12'h06e, 0, MODE_FAST}, '{1, 12'h06e, 0, MODE_FAST},
      '{1, 12'h06e, 0, MODE_FAST}, '{1, 12'h06e, 1, MODE_FAST}, '{1, 12'h06c, 1, MODE_FAST},
      '{1, 12'h06b, 0, MODE_FAST}, '{1, 12'h06e, 0, MODE_FAST}, '{1, 12'h06e, 0, MODE_FAST},
      '{1, 12'h064, 0, MODE_FAST}, '{1, 12'h06e, 0, MODE_FAST}, '{1, 12'h06e, 0, MODE_FAST},
      '{1, 12'h06e, 0, MODE_FAST}, '{0, 12'h064, 0, MODE_SYNC}};
    rst_n = 1'b0;
    sync_in = 1'b1;
    fe_value = '0;
    repeat (10) @(negedge clk);
    check(16'({burst_start, detect_out, detect_oe}), 16'h0);
    check(16'(osc_trim), 16'h0);
    check(16'(run_mode), 16'(MODE_FAST));
    rst_n = 1'b1;
    for (int i = 0; i < 14; i++) begin
      // low well before the final burst ends
      sync_in = rows[i].s;
      do_burst(rows[i].v);
      check(16'(detect_out), 16'(rows[i].d));
      check(16'(run_mode), 16'(rows[i].m));
      if (i < 13) begin
        gap_meas();
        check(16'(gap >= FG - 6 && gap <= FG + 4), 16'h1);
      end
    end
    repeat (150) begin
      @(negedge clk);
      check(16'(burst_start), 16'h0);
    end
    sync_in = 1'b1;
    repeat (2) @(negedge clk);
    check(16'(detect_oe), 16'h0);
    do_burst(12'h06e);
    check(16'(detect_out), 16'h1);
    sync_in = 1'b0;
    do_burst(12'h064);
    check(16'(detect_out), 16'h0);
    check(16'(run_mode), 16'(MODE_SYNC));
    // idle time runs from the sync edge, which lies one health phase and one burst back
    repeat (LPS - 4010) @(negedge clk);
    check(16'(run_mode), 16'(MODE_SYNC));
    repeat (20) @(negedge clk);
    check(16'(run_mode), 16'(MODE_LOW_POWER));
    do_burst(12'h064);
    gap_meas();
    check(16'(gap >= LPS - 6 && gap <= LPS + 4), 16'h1);
    do_burst(12'h06e);
    check(16'(detect_out), 16'h0);
    gap_meas();
    check(16'(gap >= FG - 6 && gap <= FG + 4), 16'h1);
    do_burst(12'h064);
    check(16'(run_mode), 16'(MODE_LOW_POWER));
    final_report();
  end
endmodule
